// ==== hw/fepcp_pkg.sv ====
// constants, code groups and helpers for the fast ethernet phy coding path
package fepcp_pkg;

	// clock and 10 Mb/s manchester timing
	localparam int CLK_MHZ        = 125;
	localparam int MAN_MID_MIN_NS = 75;
	localparam int MAN_MID_MIN_CYC = (MAN_MID_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int MAN_IDLE_NS    = 200;
	localparam int MAN_IDLE_CYC   = MAN_IDLE_NS * CLK_MHZ / 1000;
	localparam int MAN_LOCK_EDGES = 8;

	// 100 Mb/s and timing tick counts
	localparam int GRP_LAST       = 4;
	localparam int DSC_LOCK_BITS  = 60;
	localparam int DIV3_LAST      = 2;
	localparam int DIV10_STEP     = 2;
	localparam int DIV10_MOD      = 25;
	localparam int RX_CLK_HIGH    = 2;

	// reset values
	localparam logic [10:0] LFSR_RST = 11'h7ff;

	// code groups, leftmost bit sent first
	localparam logic [4:0] CG_IDLE = 5'h1f;
	localparam logic [4:0] CG_J    = 5'h18;
	localparam logic [4:0] CG_K    = 5'h11;
	localparam logic [4:0] CG_T    = 5'h0d;
	localparam logic [4:0] CG_R    = 5'h07;
	localparam logic [4:0] CG_HALT = 5'h04;
	localparam logic [9:0] CG_JK   = 10'h311;

	// line levels
	localparam logic [1:0] MLT_ZERO  = 2'h0;
	localparam logic [1:0] MLT_PLUS  = 2'h1;
	localparam logic [1:0] MLT_MINUS = 2'h3;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_K    = 4'h2,
		TX_DATA = 4'h4,
		TX_R    = 4'h8
	} fepcp_tx_state_type;

	// x^11 + x^9 + 1 key bit
	function automatic logic fepcp_key(input logic [10:0] l);
		return l[10] ^ l[8];
	endfunction

	function automatic logic [4:0] fepcp_enc(input logic [3:0] n);
		logic [4:0] g;
		unique case (n)
			4'h0: g = 5'h1e;
			4'h1: g = 5'h09;
			4'h2: g = 5'h14;
			4'h3: g = 5'h15;
			4'h4: g = 5'h0a;
			4'h5: g = 5'h0b;
			4'h6: g = 5'h0e;
			4'h7: g = 5'h0f;
			4'h8: g = 5'h12;
			4'h9: g = 5'h13;
			4'ha: g = 5'h16;
			4'hb: g = 5'h17;
			4'hc: g = 5'h1a;
			4'hd: g = 5'h1b;
			4'he: g = 5'h1c;
			4'hf: g = 5'h1d;
		endcase
		return g;
	endfunction

	// {valid, nibble}
	function automatic logic [4:0] fepcp_dec(input logic [4:0] g);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (fepcp_enc(4'(i)) == g) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

endpackage

// ==== hw/fepcp_core.sv ====
// fast ethernet phy coding path: 4b5b, scrambler, nrzi/mlt3, manchester rx
`timescale 1ns/10ps
module fepcp_core (
	// clock and reset
	input  wire logic       I_CLK,
	input  wire logic       I_ARST_N,
	// mode
	input  wire logic       I_SPEED100,
	// mii transmit
	input  wire logic [3:0] I_TXD,
	input  wire logic       I_TX_EN,
	input  wire logic       I_TX_ER,
	output logic            O_TX_NIB_STB,
	// line
	output logic      [1:0] O_TX_MLT3,
	input  wire logic [1:0] I_RX_MLT3,
	input  wire logic       I_RX_MAN,
	input  wire logic       I_RX_SQUELCH_OK,
	// mii receive
	output logic            O_RX_CLK,
	output logic      [3:0] O_RXD,
	output logic            O_RX_DV,
	output logic            O_RX_ER,
	output logic            O_RX_NIB_STB,
	output logic            O_RX_LOCK,
	// timing ticks
	output logic            O_TICK_83,
	output logic            O_TICK_41,
	output logic            O_TICK_25,
	output logic            O_TICK_10
);

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);

	// timing dividers
	logic [2:0] c5_reg;
	logic [1:0] c3_reg;
	logic [4:0] acc10_reg;
	wire        c5_last   = c5_reg == 3'(fepcp_pkg::GRP_LAST);
	wire  [2:0] c5_next   = c5_last ? 3'h0 : 3'(c5_reg + 3'h1);
	wire        c3_last   = c3_reg == 2'(fepcp_pkg::DIV3_LAST);
	wire  [4:0] acc10_sum = 5'(acc10_reg + 5'(fepcp_pkg::DIV10_STEP));
	wire        wrap10    = acc10_sum >= 5'(fepcp_pkg::DIV10_MOD);
	wire  [4:0] acc10_next = wrap10 ? 5'(acc10_sum - 5'(fepcp_pkg::DIV10_MOD)) : acc10_sum;

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			c5_reg    <= 3'h0;
			c3_reg    <= 2'h0;
			acc10_reg <= 5'h00;
			O_TICK_83 <= 1'b0;
			O_TICK_41 <= 1'b0;
			O_TICK_25 <= 1'b0;
			O_TICK_10 <= 1'b0;
			O_RX_CLK  <= 1'b0;
		end else begin
			c5_reg    <= c5_next;
			c3_reg    <= c3_last ? 2'h0 : 2'(c3_reg + 2'h1);
			acc10_reg <= acc10_next;
			O_TICK_83 <= !c3_last;
			O_TICK_41 <= c3_last;
			O_TICK_25 <= c5_last;
			O_TICK_10 <= wrap10;
			// high on counts 1..2: first pulse after reset is full width
			O_RX_CLK  <= c5_next != 3'h0 && c5_next <= 3'(fepcp_pkg::RX_CLK_HIGH);
		end
	end

	// transmit coding
	fepcp_pkg::fepcp_tx_state_type tx_state_reg, tx_state_next;
	logic [4:0]  tx_group;
	logic [4:0]  sh_reg;
	logic [10:0] lfsr_reg;
	logic        nrzi_reg;
	logic [1:0]  mlt_ph_reg;
	wire         tx_load   = c5_last;
	wire         lfsr_key  = fepcp_pkg::fepcp_key(lfsr_reg);
	wire         tx_scr    = sh_reg[4] ^ (I_SPEED100 & lfsr_key);
	wire         nrzi_next = nrzi_reg ^ tx_scr;
	wire  [1:0]  mlt_ph_next = 2'(mlt_ph_reg + {1'b0, nrzi_next != nrzi_reg});
	wire  [1:0]  mlt_level = !mlt_ph_reg[0] ? fepcp_pkg::MLT_ZERO :
	                         mlt_ph_reg[1] ? fepcp_pkg::MLT_MINUS : fepcp_pkg::MLT_PLUS;

	always_comb begin
		tx_state_next = tx_state_reg;
		tx_group      = fepcp_pkg::CG_IDLE;
		unique case (tx_state_reg)
			fepcp_pkg::TX_IDLE: begin
				if (I_TX_EN) begin
					tx_group      = fepcp_pkg::CG_J;
					tx_state_next = fepcp_pkg::TX_K;
				end
			end
			fepcp_pkg::TX_K: begin
				tx_group      = fepcp_pkg::CG_K;
				tx_state_next = fepcp_pkg::TX_DATA;
			end
			fepcp_pkg::TX_DATA: begin
				if (I_TX_EN) begin
					tx_group = I_TX_ER ? fepcp_pkg::CG_HALT : fepcp_pkg::fepcp_enc(I_TXD);
				end else begin
					tx_group      = fepcp_pkg::CG_T;
					tx_state_next = fepcp_pkg::TX_R;
				end
			end
			fepcp_pkg::TX_R: begin
				tx_group      = fepcp_pkg::CG_R;
				tx_state_next = fepcp_pkg::TX_IDLE;
			end
			default: begin
				tx_state_next = fepcp_pkg::TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			tx_state_reg <= fepcp_pkg::TX_IDLE;
			sh_reg       <= fepcp_pkg::CG_IDLE;
			lfsr_reg     <= fepcp_pkg::LFSR_RST;
			nrzi_reg     <= 1'b0;
			mlt_ph_reg   <= 2'h0;
			O_TX_MLT3    <= fepcp_pkg::MLT_ZERO;
			O_TX_NIB_STB <= 1'b0;
		end else begin
			if (!I_SPEED100) begin
				tx_state_reg <= fepcp_pkg::TX_IDLE;
			end else if (tx_load) begin
				tx_state_reg <= tx_state_next;
			end
			sh_reg       <= tx_load ? tx_group : {sh_reg[3:0], 1'b0};
			lfsr_reg     <= {lfsr_reg[9:0], lfsr_key};
			nrzi_reg     <= nrzi_next;
			mlt_ph_reg   <= mlt_ph_next;
			O_TX_MLT3    <= I_SPEED100 ? mlt_level : fepcp_pkg::MLT_ZERO;
			O_TX_NIB_STB <= I_SPEED100 && c5_reg == 3'(fepcp_pkg::GRP_LAST - 1);
		end
	end

	// 100 Mb/s receive
	logic [1:0]  rx_mlt_m_reg, rx_mlt_s_reg;
	logic        rx_nrzi_d_reg;
	logic [10:0] dsc_reg;
	logic [5:0]  dsc_cnt_reg;
	logic        dsc_lock_reg;
	logic [9:0]  win_reg;
	logic        frame_reg, rx100_dv_reg, rx100_er_reg, rx100_stb_reg;
	logic [2:0]  grp_reg;
	logic [3:0]  rx100_nib_reg;
	wire         rx_nrzi   = |rx_mlt_s_reg;
	wire         rx_nrz    = rx_nrzi ^ rx_nrzi_d_reg;
	wire         dsc_key   = fepcp_pkg::fepcp_key(dsc_reg);
	wire         dsc_match = dsc_key == !rx_nrz;
	wire         dsc_hit   = dsc_match && dsc_cnt_reg == 6'(fepcp_pkg::DSC_LOCK_BITS - 1);
	wire         rx_plain  = rx_nrz ^ dsc_key;
	wire  [9:0]  win_next  = {win_reg[8:0], rx_plain};
	wire         jk_seen   = dsc_lock_reg && !frame_reg && win_next == fepcp_pkg::CG_JK;
	wire         grp_done  = frame_reg && grp_reg == 3'(fepcp_pkg::GRP_LAST);
	wire  [4:0]  grp_dec   = fepcp_pkg::fepcp_dec(win_next[4:0]);
	wire         grp_end   = win_next[4:0] == fepcp_pkg::CG_T ||
	                         win_next[4:0] == fepcp_pkg::CG_IDLE;
	wire         frame_next = dsc_lock_reg && (jk_seen || (frame_reg && !(grp_done && grp_end)));

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rx_mlt_m_reg  <= 2'h0;
			rx_mlt_s_reg  <= 2'h0;
			rx_nrzi_d_reg <= 1'b0;
			dsc_reg       <= fepcp_pkg::LFSR_RST;
			dsc_cnt_reg   <= 6'h00;
			dsc_lock_reg  <= 1'b0;
			win_reg       <= 10'h000;
			frame_reg     <= 1'b0;
			grp_reg       <= 3'h0;
			rx100_dv_reg  <= 1'b0;
			rx100_er_reg  <= 1'b0;
			rx100_stb_reg <= 1'b0;
			rx100_nib_reg <= 4'h0;
		end else begin
			rx_mlt_m_reg  <= I_RX_MLT3;
			rx_mlt_s_reg  <= rx_mlt_m_reg;
			rx_nrzi_d_reg <= rx_nrzi;
			if (!dsc_lock_reg) begin
				dsc_reg     <= {dsc_reg[9:0], !rx_nrz};
				dsc_cnt_reg <= dsc_match ? 6'(dsc_cnt_reg + 6'h01) : 6'h00;
			end else begin
				dsc_reg <= {dsc_reg[9:0], dsc_key};
			end
			dsc_lock_reg  <= I_SPEED100 && (dsc_lock_reg || dsc_hit);
			win_reg       <= win_next;
			frame_reg     <= frame_next;
			grp_reg       <= (jk_seen || grp_done) ? 3'h0 : 3'(grp_reg + 3'h1);
			rx100_stb_reg <= grp_done && !grp_end;
			rx100_er_reg  <= grp_done && !grp_end && !grp_dec[4];
			rx100_dv_reg  <= frame_next && (rx100_dv_reg || (grp_done && !grp_end));
			if (grp_done) begin
				rx100_nib_reg <= grp_dec[3:0];
			end
		end
	end

	// 10 Mb/s manchester receive
	logic       man_m_reg, man_s_reg, man_d_reg, sq_m_reg, sq_s_reg;
	logic [4:0] ten_since_reg;
	logic [3:0] ten_edges_reg;
	logic [1:0] ten_bitc_reg;
	logic [3:0] ten_sh_reg;
	logic       ten_lock_reg, ten_dv_reg, ten_stb_reg;
	wire        ten_edge  = man_s_reg ^ man_d_reg;
	wire        ten_mid   = ten_lock_reg && ten_edge &&
	                        ten_since_reg >= 5'(fepcp_pkg::MAN_MID_MIN_CYC);
	wire        ten_clear = !sq_s_reg || I_SPEED100 ||
	                        ten_since_reg == 5'(fepcp_pkg::MAN_IDLE_CYC);
	wire        ten_lock_next = !ten_clear && (ten_lock_reg || (ten_edge &&
	                        ten_edges_reg == 4'(fepcp_pkg::MAN_LOCK_EDGES - 1)));
	wire        ten_full  = ten_mid && ten_bitc_reg == 2'h3;

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			man_m_reg     <= 1'b0;
			man_s_reg     <= 1'b0;
			man_d_reg     <= 1'b0;
			sq_m_reg      <= 1'b0;
			sq_s_reg      <= 1'b0;
			ten_since_reg <= 5'h00;
			ten_edges_reg <= 4'h0;
			ten_bitc_reg  <= 2'h0;
			ten_sh_reg    <= 4'h0;
			ten_lock_reg  <= 1'b0;
			ten_dv_reg    <= 1'b0;
			ten_stb_reg   <= 1'b0;
		end else begin
			man_m_reg    <= I_RX_MAN;
			man_s_reg    <= man_m_reg;
			man_d_reg    <= man_s_reg;
			sq_m_reg     <= I_RX_SQUELCH_OK;
			sq_s_reg     <= sq_m_reg;
			ten_lock_reg <= ten_lock_next;
			ten_stb_reg  <= ten_full;
			ten_dv_reg   <= ten_lock_next && (ten_dv_reg || ten_full);
			if (ten_clear) begin
				ten_since_reg <= 5'h00;
				ten_edges_reg <= 4'h0;
				ten_bitc_reg  <= 2'h0;
			end else begin
				// mid-bit edge restarts the bit timer
				ten_since_reg <= (ten_mid || (!ten_lock_reg && ten_edge)) ? 5'h00 :
				                 5'(ten_since_reg + 5'h01);
				if (!ten_lock_reg && ten_edge) begin
					ten_edges_reg <= 4'(ten_edges_reg + 4'h1);
				end
				if (ten_mid) begin
					ten_sh_reg   <= {man_s_reg, ten_sh_reg[3:1]};
					ten_bitc_reg <= 2'(ten_bitc_reg + 2'h1);
				end
			end
		end
	end

	// mii receive outputs
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_RXD        <= 4'h0;
			O_RX_DV      <= 1'b0;
			O_RX_ER      <= 1'b0;
			O_RX_NIB_STB <= 1'b0;
			O_RX_LOCK    <= 1'b0;
		end else begin
			O_RXD        <= I_SPEED100 ? rx100_nib_reg : ten_sh_reg;
			O_RX_DV      <= I_SPEED100 ? rx100_dv_reg : ten_dv_reg;
			O_RX_ER      <= I_SPEED100 && rx100_er_reg;
			O_RX_NIB_STB <= I_SPEED100 ? rx100_stb_reg : ten_stb_reg;
			O_RX_LOCK    <= I_SPEED100 ? dsc_lock_reg : ten_lock_reg;
		end
	end

	sequence s_ssd_j;
		sh_reg == fepcp_pkg::CG_J;
	endsequence
	sequence s_ssd_k;
		sh_reg == fepcp_pkg::CG_K;
	endsequence

	a_tx_nib_spacing: assert property (O_TX_NIB_STB |=> !O_TX_NIB_STB [*4])
		else $error("tx nibble strobes closer than five cycles");
	a_tx_ssd_order: assert property ((tx_state_reg == fepcp_pkg::TX_IDLE && tx_load
		&& I_TX_EN && I_SPEED100) |=> s_ssd_j ##5 s_ssd_k)
		else $error("start delimiter not sent as J then K");
	a_lfsr_nonzero: assert property (lfsr_reg != 11'h000)
		else $error("scrambler lfsr stuck at zero");
	a_nrzi_mlt_chain: assert property ((nrzi_reg != $past(nrzi_reg)) ==
		(mlt_ph_reg != $past(mlt_ph_reg)))
		else $error("mlt3 phase not tied to nrzi transitions");
	a_mlt3_no_jump: assert property ((O_TX_MLT3 == fepcp_pkg::MLT_PLUS) |=>
		(O_TX_MLT3 != fepcp_pkg::MLT_MINUS))
		else $error("mlt3 jumped from plus to minus");
	a_dsc_gate_dv: assert property (!dsc_lock_reg |=> !rx100_dv_reg)
		else $error("receive data valid without descrambler lock");
	a_rx_nib_spacing: assert property (rx100_stb_reg |=> !rx100_stb_reg [*4])
		else $error("receive nibbles closer than five bits");
	a_ten_squelch: assert property (!sq_s_reg |=> !ten_lock_reg ##1 !ten_dv_reg)
		else $error("10 Mb/s decode without squelch");
	a_rx_clk_free: assert property ($rose(O_RX_CLK) |-> O_RX_CLK [*2] ##1
		!O_RX_CLK [*3] ##1 O_RX_CLK)
		else $error("receive clock not running 2 high 3 low");
	a_tick10_rate: assert property (O_TICK_10 |=> !O_TICK_10 [*8] ##[4:5] O_TICK_10)
		else $error("10 MHz tick spacing not 12 or 13 cycles");

endmodule

// ==== verification/fepcp_mac_model.sv ====
// behavioural mac: sends one frame per start request, captures rx nibbles
`timescale 1ns/10ps
module fepcp_mac_model (
	// control
	input  wire logic       i_clk,
	input  wire logic       i_start,
	input  wire logic       i_inject_err,
	// mii transmit
	input  wire logic       i_tx_nib_stb,
	output logic      [3:0] o_txd,
	output logic            o_tx_en,
	output logic            o_tx_er,
	// mii receive
	input  wire logic [3:0] i_rxd,
	input  wire logic       i_rx_dv,
	input  wire logic       i_rx_er,
	input  wire logic       i_rx_nib_stb
);
	logic       start_d = 0;
	logic       start_q = 0;
	logic       pend    = 0;
	logic       run     = 0;
	int         pos     = 0;
	int         rx_n    = 0;
	logic [3:0] rx_nib [0:63];
	logic       rx_err [0:63];
	initial begin
		o_txd = 4'h0;
		o_tx_en = 0;
		o_tx_er = 0;
	end
	// new inputs only while the strobe is up, held until the next one
	always @(negedge i_clk) begin
		if (i_start && !start_d)
			pend = 1;
		start_d = i_start;
		if (i_tx_nib_stb) begin
			if (pend) begin
				pend = 0;
				run = 1;
				pos = 0;
			end
			o_tx_en = run;
			o_txd = (pos < 2) ? 4'h5 : 4'(pos - 2);
			o_tx_er = run && i_inject_err && pos == 9;
			if (run)
				pos++;
			if (pos == 18)
				run = 0;
		end
	end
	always @(posedge i_clk) begin
		start_q <= i_start;
		if (i_start && !start_q)
			rx_n <= 0;
		else if (i_rx_nib_stb && i_rx_dv) begin
			rx_nib[rx_n[5:0]] <= i_rxd;
			rx_err[rx_n[5:0]] <= i_rx_er;
			rx_n <= rx_n + 1;
		end
	end
endmodule

// ==== verification/tb.sv ====
// self-checking bench: tx to rx loopback at 100, manchester rx at 10
`timescale 1ns/10ps
module tb;
	logic       clk, arst_n, spd, man, sq, start, inj;
	logic [3:0] txd, rxd;
	logic [1:0] mlt;
	logic       txen, txer, tstb, rclk, dv, rer, rstb, lock, t83, t41, t25, t10;
	int         n_fail, samples_checked, cyc, er_cnt, rstb_cnt, tstb_cnt;
	fepcp_core u_fepcp_core (.I_CLK(clk), .I_ARST_N(arst_n), .I_SPEED100(spd),
		.I_TXD(txd), .I_TX_EN(txen), .I_TX_ER(txer), .O_TX_NIB_STB(tstb),
		.O_TX_MLT3(mlt), .I_RX_MLT3(mlt), .I_RX_MAN(man), .I_RX_SQUELCH_OK(sq),
		.O_RX_CLK(rclk), .O_RXD(rxd), .O_RX_DV(dv), .O_RX_ER(rer), .O_RX_NIB_STB(rstb),
		.O_RX_LOCK(lock), .O_TICK_83(t83), .O_TICK_41(t41), .O_TICK_25(t25),
		.O_TICK_10(t10));
	fepcp_mac_model u_fepcp_mac_model (.i_clk(clk), .i_start(start), .i_inject_err(inj),
		.i_tx_nib_stb(tstb), .o_txd(txd), .o_tx_en(txen), .o_tx_er(txer),
		.i_rxd(rxd), .i_rx_dv(dv), .i_rx_er(rer), .i_rx_nib_stb(rstb));
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (rer) er_cnt++;
		if (rstb) rstb_cnt++;
		if (tstb) tstb_cnt++;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic do_reset(input logic s);
		@(negedge clk);
		arst_n = 0;
		spd = s;
		repeat (4) @(negedge clk);
		arst_n = 1;
	endtask
	task automatic t_clk();
		int h, a, b, c, d, s0;
		h = 0;
		a = 0;
		b = 0;
		c = 0;
		d = 0;
		s0 = tstb_cnt;
		repeat (75) begin
			@(negedge clk);
			h += rclk;
			a += t83;
			b += t41;
			c += t25;
			d += t10;
		end
		check("tx_strobes", tstb_cnt - s0, 15);
		check("rx_clk_high", h, 30);
		check("tick83", a, 50);
		check("tick41", b, 25);
		check("tick25", c, 15);
		check("tick10", d, 6);
		$display("test clocks done");
	endtask
	task automatic t_lock();
		int k;
		k = 0;
		while (lock !== 1'b1 && k < 500) begin
			@(negedge clk);
			k++;
		end
		check("lock_idle", lock, 1);
		check("dv_idle", dv, 0);
		$display("test lock done");
	endtask
	task automatic t_frame(input logic err);
		int k;
		@(negedge clk);
		inj = err;
		start = 1;
		k = 0;
		while (dv !== 1'b1 && k < 400) begin
			@(negedge clk);
			k++;
		end
		start = 0;
		check("dv_rise", dv, 1);
		k = 0;
		while (dv !== 1'b0 && k < 600) begin
			@(negedge clk);
			k++;
		end
		check("rx_count", u_fepcp_mac_model.rx_n, 16);
		for (int i = 0; i < 16; i++) begin
			check("rx_err", u_fepcp_mac_model.rx_err[i], err && i == 7);
			if (!(err && i == 7))
				check("rx_nib", u_fepcp_mac_model.rx_nib[i], i);
		end
		$display("test frame done");
	endtask
	task automatic man_bit(input logic b);
		man = ~b;
		repeat (6) @(negedge clk);
		man = b;
		repeat (6) @(negedge clk);
	endtask
	task automatic t_man();
		int s0, t0, e0, n;
		do_reset(0);
		sq = 0;
		s0 = rstb_cnt;
		t0 = tstb_cnt;
		e0 = er_cnt;
		for (int i = 0; i < 16; i++)
			man_bit(i[0]);
		check("lock_nosq", lock, 0);
		check("stb_nosq", rstb_cnt - s0, 0);
		sq = 1;
		for (int i = 0; i < 8; i++)
			man_bit(i[0]);
		for (int i = 0; i < 24; i++)
			man_bit(!i[1]);
		n = u_fepcp_mac_model.rx_n - 1;
		check("man_lock", lock, 1);
		check("man_stb", rstb_cnt - s0, 6);
		check("man_nib", u_fepcp_mac_model.rx_nib[n[5:0]], 4'h3);
		check("man_er", er_cnt - e0, 0);
		check("tx_quiet", mlt, 2'h0);
		check("tx_nostb", tstb_cnt - t0, 0);
		sq = 0;
		repeat (6) @(negedge clk);
		check("lock_drop", lock, 0);
		check("dv_drop", dv, 0);
		$display("test manchester done");
	endtask
	initial begin
		arst_n = 0;
		spd = 1;
		man = 0;
		sq = 0;
		start = 0;
		inj = 0;
		n_fail = 0;
		samples_checked = 0;
		cyc = 0;
		er_cnt = 0;
		rstb_cnt = 0;
		tstb_cnt = 0;
		do_reset(1);
		t_clk();
		t_lock();
		t_frame(1'b0);
		t_frame(1'b1);
		t_man();
		print_verdict();
	end
endmodule
